// ---- src/lgl_pkg.sv ----
// constants shared by the log gamma lookup block
// How it works
// RL1 - log mode follows a 513 point curve with power-of-two segment widths
// RL2 - each segment holds equally spaced points, counts fixed per segment
// RL3 - points 0..509 live in the palette, 0.16, high bits odd, low even
// RL4 - inputs in [0,1) interpolate between neighbours among the first 511
// RL5 - point 510 sits in the maximum point register as 1.16
// RL6 - inputs in [1,3) interpolate points 510 and 511; 511 is 3.16
// RL7 - inputs in [3,7) interpolate points 511 and 512; 512 is 3.16
// RL8 - every input is clamped inside the open range minus seven to seven
// RL9 - negative inputs give the negated result of their magnitude
// RL10 - software sets the first point to zero when inputs can go negative
// RL11 - software loads a non-decreasing curve over inputs zero to seven
// RL12 - interpolated mode: point number is input times 512
// RL13 - interpolated mode: value for input three goes to point 514
// RL14 - log mode: software loads the first 510 points via palette access
// RL15 - log mode: value for input one goes to the maximum point
// RL16 - log mode: value for input three goes to the extended point
// RL17 - log mode: value for input seven goes to the second extended point
// RL18 - software saturates values to the destination register width
// RL19 - each pixel is corrected or passed by its plane gamma enable
// RL20 - the curve applies only while the mode setting selects log mode
package lgl_pkg;
    localparam int NCOL = 3;
    localparam int IN_W = 20;
    localparam int MAG_W = 19;
    localparam int FRAC_W = 16;
    localparam int PT_W = 16;
    localparam int MAX_W = 17;
    localparam int EXT_W = 19;
    localparam int PT_AW = 9;
    localparam int IDX_W = 10;
    localparam int FLD_W = 10;
    localparam int LO_W = 6;
    localparam int U_W = 24;
    localparam int SEG_N = 24;
    localparam int EXT1_SH = 1;
    localparam int EXT2_SH = 2;
    localparam logic [PT_AW-1:0] PAL_LAST = 9'h1FD;
    localparam logic [IDX_W-1:0] IDX_END = 10'h3FC;
    localparam logic [MAG_W-1:0] MAG_MAX = 19'h6FFFF;
    localparam logic [MAG_W-1:0] ONE = 19'h10000;
    localparam logic [MAG_W-1:0] THREE = 19'h30000;
    localparam logic [1:0] RGN_PAL = 2'h0;
    localparam logic [1:0] RGN_EXT1 = 2'h1;
    localparam logic [1:0] RGN_EXT2 = 2'h2;
    localparam int MODE_W = 2;
    localparam logic [MODE_W-1:0] MODE_LOG = 2'h3;
    localparam logic [MODE_W-1:0] MODE_RST = 2'h0;
    localparam int ADR_W = 8;
    localparam int COL_LSB = 2;
    localparam int GRP_LSB = 4;
    localparam logic [ADR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] A_INDEX = 8'h04;
    localparam logic [ADR_W-1:0] A_DATA = 8'h08;
    localparam logic [ADR_W-1:0] A_STAT = 8'h0C;
    localparam logic [ADR_W-1:0] A_MAX = 8'h10;
    localparam logic [ADR_W-1:0] A_EXT1 = 8'h20;
    localparam logic [ADR_W-1:0] A_EXT2 = 8'h30;
endpackage

// ---- src/lgl_mem.sv ----
// palette point memory, one write port, two registered read ports
module lgl_mem #(
    parameter int W = 16,
    parameter int AW = 9
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [W-1:0] rdata_a,
    output logic [W-1:0] rdata_b
);
    logic [W-1:0] mem [1<<AW];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule

// ---- src/lgl_locate.sv ----
// maps a clamped magnitude to curve point, fraction and region
module lgl_locate (
    // clamped magnitude, 3.16
    input wire logic [lgl_pkg::MAG_W-1:0] mag,
    // curve position
    output logic [lgl_pkg::PT_AW-1:0] idx,
    output logic [lgl_pkg::FRAC_W-1:0] frac,
    output logic [1:0] region
);
    // log2 of the point count per power-of-two segment
    function automatic logic [4:0] seg_log2n(input logic [4:0] x);
        logic [4:0] k;
        case (x) inside
            [5'h01:5'h04]: k = 5'h01;
            [5'h05:5'h07]: k = 5'h02;
            [5'h08:5'h0A]: k = 5'h03;
            [5'h0B:5'h0D]: k = 5'h04;
            [5'h0E:5'h0F]: k = 5'h05;
            [5'h10:5'h12]: k = 5'h06;
            [5'h13:5'h17]: k = 5'h05;
            default: k = 5'h00;
        endcase
        return k;
    endfunction

    // first point of segment x; point 0 sits at zero
    function automatic logic [8:0] seg_base(input logic [4:0] x);
        logic [8:0] b;
        b = 9'h001;
        for (int y = 0; y < lgl_pkg::SEG_N; y++) begin
            if (5'(y) < x) begin
                b = b + (9'h001 << seg_log2n(5'(y)));
            end
        end
        return b;
    endfunction

    logic [lgl_pkg::U_W-1:0] u;
    logic [lgl_pkg::U_W-1:0] off;
    logic [lgl_pkg::U_W-1:0] fr;
    logic [lgl_pkg::MAG_W-1:0] d;
    logic [4:0] x;
    logic [4:0] s;

    always_comb begin
        u = lgl_pkg::U_W'(mag[lgl_pkg::FRAC_W-1:0])
            << (lgl_pkg::U_W - lgl_pkg::FRAC_W);
        x = 5'h00;
        for (int i = 0; i < lgl_pkg::U_W; i++) begin
            if (u[i]) begin
                x = 5'(i);
            end
        end
        s = x - seg_log2n(x);
        off = u - (lgl_pkg::U_W'(1) << x);
        fr = off << (5'(lgl_pkg::U_W) - s);
        d = lgl_pkg::MAG_W'(0);
        region = lgl_pkg::RGN_PAL;
        idx = lgl_pkg::PT_AW'(0);
        frac = lgl_pkg::FRAC_W'(0);
        if (mag >= lgl_pkg::THREE) begin
            d = mag - lgl_pkg::THREE;
            region = lgl_pkg::RGN_EXT2; // [RL7]
            frac = d[lgl_pkg::EXT2_SH +: lgl_pkg::FRAC_W];
        end else if (mag >= lgl_pkg::ONE) begin
            d = mag - lgl_pkg::ONE;
            region = lgl_pkg::RGN_EXT1; // [RL6]
            frac = d[lgl_pkg::EXT1_SH +: lgl_pkg::FRAC_W];
        end else if (u != lgl_pkg::U_W'(0)) begin
            // segment base plus equal step inside it
            idx = seg_base(x) + 9'(off >> s); // [RL1] [RL2]
            frac = fr[lgl_pkg::U_W-1 -: lgl_pkg::FRAC_W];
        end
    end
endmodule

// ---- src/lgl_gamma.sv ----
// log gamma lookup stage with wishbone register slave
//
// The Wishbone slave port and the register offsets were decided locally.
module lgl_gamma (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [lgl_pkg::ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // blended pixels in
    input wire logic pix_in_valid,
    input wire logic pix_in_gamma_en,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_in_c0,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_in_c1,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_in_c2,
    // corrected pixels out
    output logic pix_out_valid,
    output logic signed [lgl_pkg::IN_W-1:0] pix_out_c0,
    output logic signed [lgl_pkg::IN_W-1:0] pix_out_c1,
    output logic signed [lgl_pkg::IN_W-1:0] pix_out_c2
);
    localparam int NC = lgl_pkg::NCOL;
    localparam int IW = lgl_pkg::IN_W;
    localparam int EW = lgl_pkg::EXT_W;
    localparam int FW = lgl_pkg::FRAC_W;

    // byte-lane merge of a write onto a stored word
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // straight line between two points at fraction f
    function automatic logic signed [IW-1:0] lerp(input logic [EW-1:0] a,
                                                  input logic [EW-1:0] b,
                                                  input logic [FW-1:0] f);
        logic signed [EW+1:0] d;
        logic signed [EW+FW+2:0] p;
        d = $signed({2'b00, b}) - $signed({2'b00, a});
        p = d * $signed({1'b0, f});
        return IW'($signed({1'b0, a}) + (p >>> FW));
    endfunction

    // register state
    logic [lgl_pkg::MODE_W-1:0] mode_r;
    logic [lgl_pkg::IDX_W-1:0] idx_r;
    logic [lgl_pkg::LO_W-1:0] stash_r [NC];
    logic [lgl_pkg::MAX_W-1:0] maxp_r [NC];
    logic [EW-1:0] ext1_r [NC];
    logic [EW-1:0] ext2_r [NC];
    logic [31:0] cnt_r;
    logic ack_r;
    logic [31:0] rd_r;

    // pipeline state
    logic v1_r;
    logic v2_r;
    logic s1_corr_r;
    logic [FW-1:0] s1_frac_r [NC];
    logic [1:0] s1_rgn_r [NC];
    logic s1_neg_r [NC];
    logic [lgl_pkg::PT_AW-1:0] s1_idx_r [NC];
    logic signed [IW-1:0] s1_byp_r [NC];
    logic signed [IW-1:0] out_r [NC];

    // bus decode
    wire req = wb_cyc & wb_stb & ~ack_r;
    wire wr = req & wb_we;
    wire [1:0] col = wb_adr[lgl_pkg::COL_LSB +: 2];
    wire col_ok = col < 2'(NC);
    wire [lgl_pkg::ADR_W-1:0] grp = {wb_adr[lgl_pkg::ADR_W-1:
                                            lgl_pkg::GRP_LSB], 4'h0};
    wire hit_ctrl = wb_adr == lgl_pkg::A_CTRL;
    wire hit_index = wb_adr == lgl_pkg::A_INDEX;
    wire hit_data = wb_adr == lgl_pkg::A_DATA;
    wire hit_stat = wb_adr == lgl_pkg::A_STAT;
    wire hit_max = grp == lgl_pkg::A_MAX && col_ok;
    wire hit_ext1 = grp == lgl_pkg::A_EXT1 && col_ok;
    wire hit_ext2 = grp == lgl_pkg::A_EXT2 && col_ok;
    wire [31:0] cur_max = hit_max ? 32'(maxp_r[col]) : 32'h0;
    wire [31:0] cur_e1 = hit_ext1 ? 32'(ext1_r[col]) : 32'h0;
    wire [31:0] cur_e2 = hit_ext2 ? 32'(ext2_r[col]) : 32'h0;
    wire [31:0] cur_pt = cur_max | cur_e1 | cur_e2;
    wire [31:0] wd_pt = wmerge(cur_pt, wb_dat_w, wb_sel);
    wire [31:0] wd_ctrl = wmerge(32'(mode_r), wb_dat_w, wb_sel);
    wire [31:0] wd_idx = wmerge(32'(idx_r), wb_dat_w, wb_sel);
    wire [31:0] wd_data = wmerge(32'h0, wb_dat_w, wb_sel);
    wire [31:0] rd_val = hit_ctrl ? 32'(mode_r)
                       : hit_index ? 32'(idx_r)
                       : hit_stat ? cnt_r
                       : cur_pt;

    // palette access: low bits stashed at even, point written at odd
    wire data_wr = wr & hit_data;
    wire mem_we = data_wr & idx_r[0] & (idx_r < lgl_pkg::IDX_END); // [RL3]
    wire [lgl_pkg::PT_AW-1:0] mem_wa = idx_r[lgl_pkg::IDX_W-1:1];
    logic [lgl_pkg::PT_W-1:0] mem_wd [NC];
    logic [lgl_pkg::PT_W-1:0] rda [NC];
    logic [lgl_pkg::PT_W-1:0] rdb [NC];

    // curve applies only in log mode with plane gamma enabled
    wire corr = pix_in_gamma_en && mode_r == lgl_pkg::MODE_LOG; // [RL19] [RL20]

    logic signed [IW-1:0] pin [NC];
    logic [IW-1:0] absu [NC];
    logic [lgl_pkg::MAG_W-1:0] mag [NC];
    logic [lgl_pkg::PT_AW-1:0] idx0 [NC];
    logic [FW-1:0] frac0 [NC];
    logic [1:0] rgn0 [NC];
    logic [EW-1:0] pa [NC];
    logic [EW-1:0] pb [NC];
    logic signed [IW-1:0] y [NC];
    logic signed [IW-1:0] res [NC];

    assign pin[0] = pix_in_c0;
    assign pin[1] = pix_in_c1;
    assign pin[2] = pix_in_c2;

    for (genvar c = 0; c < NC; c++) begin : g_col
        assign mem_wd[c] = {wd_data[c*lgl_pkg::FLD_W +: lgl_pkg::FLD_W],
                            stash_r[c]};
        // magnitude then clamp below seven
        assign absu[c] = pin[c][IW-1] ? IW'(-pin[c]) : pin[c]; // [RL9]
        assign mag[c] = (absu[c] > IW'(lgl_pkg::MAG_MAX)) ? lgl_pkg::MAG_MAX
                      : absu[c][lgl_pkg::MAG_W-1:0]; // [RL8]

        lgl_locate u_loc (
            .mag(mag[c]),
            .idx(idx0[c]),
            .frac(frac0[c]),
            .region(rgn0[c])
        );

        lgl_mem #(
            .W(lgl_pkg::PT_W),
            .AW(lgl_pkg::PT_AW)
        ) u_mem (
            .clk(sys_clk),
            .we(mem_we),
            .waddr(mem_wa),
            .wdata(mem_wd[c]),
            .raddr_a(idx0[c]),
            .raddr_b(idx0[c] + 9'h001),
            .rdata_a(rda[c]),
            .rdata_b(rdb[c])
        );

        // neighbour points per region
        assign pa[c] = s1_rgn_r[c] == lgl_pkg::RGN_EXT2 ? ext1_r[c]
                     : s1_rgn_r[c] == lgl_pkg::RGN_EXT1 ? EW'(maxp_r[c])
                     : EW'(rda[c]); // [RL4] [RL6] [RL7]
        assign pb[c] = s1_rgn_r[c] == lgl_pkg::RGN_EXT2 ? ext2_r[c]
                     : s1_rgn_r[c] == lgl_pkg::RGN_EXT1 ? ext1_r[c]
                     : s1_idx_r[c] == lgl_pkg::PAL_LAST ? EW'(maxp_r[c])
                     : EW'(rdb[c]); // [RL5]
        assign y[c] = lerp(pa[c], pb[c], s1_frac_r[c]); // [RL4]
        assign res[c] = !s1_corr_r ? s1_byp_r[c]
                      : s1_neg_r[c] ? IW'(-y[c]) : y[c]; // [RL9] [RL19]
    end

    assign wb_dat_r = rd_r;
    assign wb_ack = ack_r;
    assign pix_out_valid = v2_r;
    assign pix_out_c0 = out_r[0];
    assign pix_out_c1 = out_r[1];
    assign pix_out_c2 = out_r[2];

    // bus side registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
            rd_r <= 32'h0;
            mode_r <= lgl_pkg::MODE_RST;
            idx_r <= lgl_pkg::IDX_W'(0);
            cnt_r <= 32'h0;
            for (int c = 0; c < NC; c++) begin
                stash_r[c] <= lgl_pkg::LO_W'(0);
                maxp_r[c] <= lgl_pkg::MAX_W'(0);
                ext1_r[c] <= EW'(0);
                ext2_r[c] <= EW'(0);
            end
        end else begin
            ack_r <= req;
            if (req) begin
                rd_r <= wb_we ? 32'h0 : rd_val;
            end
            if (wr && hit_ctrl) begin
                mode_r <= wd_ctrl[lgl_pkg::MODE_W-1:0]; // [RL20]
            end
            if (wr && hit_index) begin
                idx_r <= wd_idx[lgl_pkg::IDX_W-1:0];
            end else if (data_wr) begin
                idx_r <= idx_r + 10'h001;
            end
            for (int c = 0; c < NC; c++) begin
                if (data_wr && !idx_r[0]) begin
                    stash_r[c] <=
                        wd_data[c*lgl_pkg::FLD_W +: lgl_pkg::LO_W]; // [RL3]
                end
                if (wr && hit_max && col == 2'(c)) begin
                    maxp_r[c] <= wd_pt[lgl_pkg::MAX_W-1:0]; // [RL5]
                end
                if (wr && hit_ext1 && col == 2'(c)) begin
                    ext1_r[c] <= wd_pt[EW-1:0]; // [RL6]
                end
                if (wr && hit_ext2 && col == 2'(c)) begin
                    ext2_r[c] <= wd_pt[EW-1:0]; // [RL7]
                end
            end
            if (v1_r && s1_corr_r) begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end

    // pixel pipeline, two stages
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            v1_r <= 1'b0;
            v2_r <= 1'b0;
            s1_corr_r <= 1'b0;
            for (int c = 0; c < NC; c++) begin
                s1_frac_r[c] <= FW'(0);
                s1_rgn_r[c] <= lgl_pkg::RGN_PAL;
                s1_neg_r[c] <= 1'b0;
                s1_idx_r[c] <= lgl_pkg::PT_AW'(0);
                s1_byp_r[c] <= IW'(0);
                out_r[c] <= IW'(0);
            end
        end else begin
            v1_r <= pix_in_valid;
            v2_r <= v1_r;
            s1_corr_r <= corr;
            for (int c = 0; c < NC; c++) begin
                s1_frac_r[c] <= frac0[c];
                s1_rgn_r[c] <= rgn0[c];
                s1_neg_r[c] <= pin[c][IW-1];
                s1_idx_r[c] <= idx0[c];
                s1_byp_r[c] <= pin[c];
                out_r[c] <= res[c];
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence corr_in_s;
        pix_in_valid && pix_in_gamma_en && mode_r == lgl_pkg::MODE_LOG;
    endsequence

    pixel_latency_a: assert property ( // [RL19]
        pix_in_valid |-> ##2 pix_out_valid)
        else $error("pixel not delivered two cycles later");
    bypass_pass_a: assert property ( // [RL19]
        pix_in_valid && !pix_in_gamma_en
        |-> ##2 pix_out_c0 == $past(pix_in_c0, 2))
        else $error("disabled plane pixel was altered");
    mode_gate_a: assert property ( // [RL20]
        pix_in_valid && mode_r != lgl_pkg::MODE_LOG
        |-> ##2 pix_out_c1 == $past(pix_in_c1, 2))
        else $error("pixel altered outside log mode");
    clamp_top_a: assert property ( // [RL8]
        pix_in_c0 >= 20'sh70000 |=> s1_rgn_r[0] == lgl_pkg::RGN_EXT2
        && s1_frac_r[0] == 16'hFFFF)
        else $error("large input not clamped below seven");
    mirror_sign_a: assert property ( // [RL9]
        corr_in_s ##0 pix_in_c2 < 0 |-> ##2 pix_out_c2 <= 0)
        else $error("negative input gave positive result");
    seg_start_a: assert property ( // [RL2]
        pix_in_c0 == 20'sh08000 |=> s1_idx_r[0] == 9'h1DE
        && s1_frac_r[0] == 16'h0000)
        else $error("last segment does not start at point 478");
    pal_end_a: assert property ( // [RL4]
        pix_in_c1 == 20'sh0FFFF |=> s1_idx_r[1] == lgl_pkg::PAL_LAST
        && s1_rgn_r[1] == lgl_pkg::RGN_PAL && s1_frac_r[1] == 16'hFFC0)
        else $error("input below one misplaced on the curve");
    max_point_a: assert property ( // [RL5]
        v1_r && s1_rgn_r[0] == lgl_pkg::RGN_PAL
        && s1_idx_r[0] == lgl_pkg::PAL_LAST
        |-> pb[0] == EW'(maxp_r[0]))
        else $error("point 510 not taken from maximum register");
    ext_one_a: assert property ( // [RL6]
        pix_in_c0 == 20'sh20000 |=> s1_rgn_r[0] == lgl_pkg::RGN_EXT1
        && s1_frac_r[0] == 16'h8000)
        else $error("input two not halfway in first extension");
    ext_two_a: assert property ( // [RL7]
        pix_in_c0 == 20'sh50000 |=> s1_rgn_r[0] == lgl_pkg::RGN_EXT2
        && s1_frac_r[0] == 16'h8000)
        else $error("input five not halfway in second extension");
    pal_write_a: assert property ( // [RL3]
        mem_we |-> idx_r[0] && mem_wd[0][lgl_pkg::LO_W-1:0] == stash_r[0])
        else $error("point written from even index or stale low bits");
    stash_take_a: assert property ( // [RL3]
        data_wr && !idx_r[0]
        |=> stash_r[1] == $past(wd_data[lgl_pkg::FLD_W +: lgl_pkg::LO_W]))
        else $error("low bits of even write not kept");
endmodule

// ---- test/lgl_pipe_model.sv ----
// pixel pipe partner: blender source and downstream sink
module lgl_pipe_model (
    // clock
    input wire logic clk,
    // blender side
    output logic pix_in_valid,
    output logic pix_in_gamma_en,
    output logic signed [lgl_pkg::IN_W-1:0] pix_in_c0,
    output logic signed [lgl_pkg::IN_W-1:0] pix_in_c1,
    output logic signed [lgl_pkg::IN_W-1:0] pix_in_c2,
    // downstream side
    input wire logic pix_out_valid,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_out_c0,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_out_c1,
    input wire logic signed [lgl_pkg::IN_W-1:0] pix_out_c2
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [59:0] got_q[$];
    int lat_q[$];
    int sent_q[$];
    int cyc = 0;
    initial begin
        pix_in_valid = 1'b0;
        pix_in_gamma_en = 1'b0;
        pix_in_c0 = 20'h00000;
        pix_in_c1 = 20'h00000;
        pix_in_c2 = 20'h00000;
    end
    // stamps taken pixels, collects results with their latency
    always @(posedge clk) begin
        cyc++;
        if (pix_in_valid === 1'b1)
            sent_q.push_back(cyc);
        if (pix_out_valid === 1'b1) begin
            got_q.push_back({pix_out_c2, pix_out_c1, pix_out_c0});
            lat_q.push_back(cyc - sent_q.pop_front());
        end
    end
    // one pixel, same input on all three components
    task automatic send(input logic en, input logic [19:0] x);
        @(posedge clk);
        pix_in_valid <= 1'b1;
        pix_in_gamma_en <= en;
        pix_in_c0 <= x;
        pix_in_c1 <= x;
        pix_in_c2 <= x;
    endtask
    // no pixel; stale lines flip so they are never mistaken for data
    task automatic idle();
        @(posedge clk);
        pix_in_valid <= 1'b0;
        pix_in_gamma_en <= ~pix_in_gamma_en;
        pix_in_c0 <= ~pix_in_c0;
        pix_in_c1 <= ~pix_in_c1;
        pix_in_c2 <= ~pix_in_c2;
    endtask
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the log gamma lookup block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic pix_in_valid;
    logic pix_in_gamma_en;
    logic signed [lgl_pkg::IN_W-1:0] pix_in_c0, pix_in_c1, pix_in_c2;
    logic pix_out_valid;
    logic signed [lgl_pkg::IN_W-1:0] pix_out_c0, pix_out_c1, pix_out_c2;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc_cnt = 0;
    logic [59:0] exp_q[$];
    logic [31:0] rd;
    always #5 sys_clk = ~sys_clk;
    lgl_gamma i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .pix_in_valid(pix_in_valid), .pix_in_gamma_en(pix_in_gamma_en),
        .pix_in_c0(pix_in_c0), .pix_in_c1(pix_in_c1), .pix_in_c2(pix_in_c2),
        .pix_out_valid(pix_out_valid), .pix_out_c0(pix_out_c0),
        .pix_out_c1(pix_out_c1), .pix_out_c2(pix_out_c2));
    lgl_pipe_model i_pipe (.clk(sys_clk), .pix_in_valid(pix_in_valid),
        .pix_in_gamma_en(pix_in_gamma_en), .pix_in_c0(pix_in_c0),
        .pix_in_c1(pix_in_c1), .pix_in_c2(pix_in_c2),
        .pix_out_valid(pix_out_valid), .pix_out_c0(pix_out_c0),
        .pix_out_c1(pix_out_c1), .pix_out_c2(pix_out_c2));
    task automatic summarize();
        $display("mismatches %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // classic single cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [31:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= d;
        wb_sel <= sel;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        if (n >= 40)
            error_cnt++;
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
        wb_xfer(1'b0, adr, 32'h0, 4'hF);
        `CHK(rd, e)
    endtask
    function automatic int cnt(int x);
        if (x == 0) return 1;
        if (x <= 4) return 2;
        if (x <= 7) return 4;
        if (x <= 10) return 8;
        if (x <= 13) return 16;
        if (x <= 15) return 32;
        if (x <= 18) return 64;
        return 32;
    endfunction
    // loaded curve: linear palette per colour, fixed top points
    function automatic longint pt(int col, int k);
        if (k > 511) return 64'h40000;
        if (k > 510) return 64'h20000;
        if (k > 509) return 64'h10000;
        return k * (32 << col);
    endfunction
    function automatic logic [19:0] ex(int col, logic [19:0] x, logic on);
        longint m, u, fr, a, res, st, r;
        int idx, h, b;
        if (!on) return x;
        m = x[19] ? 64'h100000 - x : x;
        if (m > 64'h6FFFF) m = 64'h6FFFF;
        u = m << 8;
        idx = 511;
        fr = (m - 64'h30000) >> 2;
        if (m < 64'h30000) begin
            idx = 510;
            fr = (m - 64'h10000) >> 1;
        end
        if (m < 64'h10000) begin
            h = 0;
            b = 1;
            idx = 0;
            fr = 0;
            if (u != 0) begin
                while ((u >> (h + 1)) != 0) begin
                    b += cnt(h);
                    h++;
                end
                st = (64'h1 << h) / cnt(h);
                r = u - (64'h1 << h);
                idx = b + int'(r / st);
                fr = ((r % st) << 16) / st;
            end
        end
        a = pt(col, idx);
        res = a + (((pt(col, idx + 1) - a) * fr) >>> 16);
        if (x[19]) res = -res;
        return res[19:0];
    endfunction
    task automatic px(input logic en, input logic [19:0] x, input logic lm);
        i_pipe.send(en, x);
        exp_q.push_back({ex(2, x, en & lm), ex(1, x, en & lm),
                         ex(0, x, en & lm)});
    endtask
    task automatic drain();
        logic [59:0] g, e;
        int lat;
        repeat (5) i_pipe.idle();
        `CHK(i_pipe.got_q.size(), exp_q.size())
        while (exp_q.size() > 0 && i_pipe.got_q.size() > 0) begin
            g = i_pipe.got_q.pop_front();
            e = exp_q.pop_front();
            lat = i_pipe.lat_q.pop_front();
            `CHK(g, e)
            `CHK(lat, 2)
        end
        exp_q.delete();
    endtask
    task automatic t_reset();
        `CHK(pix_out_valid, 1'b0)
        rd_chk(lgl_pkg::A_CTRL, 32'h0);
        rd_chk(lgl_pkg::A_INDEX, 32'h0);
        rd_chk(8'h40, 32'h0);
    endtask
    task automatic t_load();
        logic [15:0] v;
        logic [31:0] lo, hi;
        logic [7:0] adr;
        lo = 32'h0;
        hi = 32'h0;
        wb_xfer(1'b1, lgl_pkg::A_INDEX, 32'h0, 4'hF);
        for (int k = 0; k < 510; k++) begin
            for (int c = 0; c < 3; c++) begin
                v = 16'(pt(c, k));
                lo[c*10 +: 10] = {4'h0, v[5:0]};
                hi[c*10 +: 10] = v[15:6];
            end
            wb_xfer(1'b1, lgl_pkg::A_DATA, lo, 4'hF);
            wb_xfer(1'b1, lgl_pkg::A_DATA, hi, 4'hF);
        end
        rd_chk(lgl_pkg::A_INDEX, 32'h3FC);
        rd_chk(lgl_pkg::A_DATA, 32'h0);
        for (int g = 1; g < 4; g++) begin
            for (int c = 0; c < 3; c++) begin
                adr = 8'(g * 16 + c * 4);
                wb_xfer(1'b1, adr, 32'hFFFFFFFF, 4'hF);
                rd_chk(adr, g == 1 ? 32'h1FFFF : 32'h7FFFF);
                wb_xfer(1'b1, adr, 32'(pt(c, 509 + g)), 4'hF);
                rd_chk(adr, 32'(pt(c, 509 + g)));
            end
        end
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wb_xfer(1'b1, lgl_pkg::A_CTRL, 32'(m), 4'hF);
            px(1'b1, 20'h08000, m == 3);
            drain();
        end
        px(1'b0, 20'h0A5A5, 1'b1);
        px(1'b1, 20'h0A5A5, 1'b1);
        drain();
        wb_xfer(1'b1, lgl_pkg::A_CTRL, 32'h0, 4'h0);
        rd_chk(lgl_pkg::A_CTRL, 32'h3);
    endtask
    task automatic t_curve();
        logic [19:0] tbl[12] = '{20'h00000, 20'h00001, 20'h00100,
            20'h08000, 20'h0FFFF, 20'h10000, 20'h1C000, 20'h30000,
            20'h5A5A5, 20'h7FFFF, 20'hF8000, 20'h80000};
        foreach (tbl[i]) px(1'b1, tbl[i], 1'b1);
        drain();
    endtask
    task automatic t_status();
        wb_xfer(1'b1, lgl_pkg::A_STAT, 32'h0, 4'hF);
        rd_chk(lgl_pkg::A_STAT, 32'd14);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_load();
        t_modes();
        t_curve();
        t_status();
        summarize();
    end
endmodule
